/* File: rtl/oafe_irq_regs.sv */
`timescale 1ns/1ps

module oafe_irq_regs
   import oafe_pkg::*;
#(
   parameter logic [7:0] PART_IDENTITY_FIELD_VALUE = 8'h5A,  // arbitrary identity value
   parameter int         DEPTH         = FIFO_DEPTH  // sample buffer depth
) (
   input  logic                 clk_sys,          // system clock, 250 MHz
   input  logic                 reset_n,          // async reset, active low
   input  logic                 clkEn,            // freezes all state when low
   input  oafe_spi_t            spiPins,          // raw serial pins
   output logic                 sdoData,          // serial data out
   output logic                 sdoOe,            // serial out enable
   input  oafe_evt_t            evtIn,            // measurement events
   input  logic [LEVEL_W-1:0]   fifoLevel,        // buffer occupancy
   input  logic [7:0]           fifoData,         // byte at buffer head
   output logic                 fifoPop,          // data port read pulse
   input  logic [COUNT_W-1:0]   firstLedCount,    // first LED converter count
   output logic                 intReq_n,         // interrupt, active low
   output logic                 proxModeActive,   // proximity mode flag
   output logic [7:0]           firstLedDrive,    // first LED current in use
   output logic [7:0]           secondLedCurrent, // second LED current
   output logic [7:0]           slotSourceA,      // slot one/two sources
   output logic [7:0]           slotSourceB,      // slot three/four sources
   output logic [7:0]           systemCtrl,       // system control bits
   output logic [7:0]           samplingCfg1,     // range and integration
   output logic [7:0]           samplingCfg2,     // settle and averaging
   output logic [7:0]           ledCurrentRange   // Led_current_range fields
);

   // pin synchronisers
   oafe_spi_t           syncA_r;        // first stage, read only by syncB_r
   oafe_spi_t           syncB_r;        // second stage
   logic                sclkPrev_r;     // previous synced clock
   // serial engine
   logic [4:0]          bitCnt_r;       // bits received in frame
   logic [6:0]          shiftIn_r;      // received bits
   logic [7:0]          addr_r;         // latched register address
   logic                isWrite_r;      // frame is a write
   logic [7:0]          shiftOut_r;     // read data shifter
   logic                sdoOe_r;        // output enable flop
   // configuration registers
   logic [7:0]          slotA_r;        // slot_source_ctrl_a
   logic [7:0]          slotB_r;        // slot_source_ctrl_b
   logic [7:0]          sysCtl_r;       // system_control
   logic [7:0]          cfg1_r;         // sampling_config_one
   logic [7:0]          cfg2_r;         // sampling_config_two
   logic [7:0]          proxThr_r;      // proximity_threshold_reg
   logic [7:0]          led1_r;         // first_led_amplitude
   logic [7:0]          led2_r;         // second_led_amplitude
   logic [7:0]          range_r;        // led_current_range
   logic [7:0]          pilot_r;        // pilot_led_amplitude
   logic [7:0]          intEn_r;        // interrupt enables
   logic [7:0]          fifoCfg_r;      // clear option and almost-full level
   // status and mode
   logic [7:0]          status_r;       // interrupt_status_one
   oafe_prox_t          proxState_r;    // proximity mode state
   oafe_prox_t          proxState_nxt;  // next proximity state
   logic                intReq_n_r;     // interrupt output flop
   logic [7:0]          ledDrive_r;     // first LED current flop
   // combinational
   logic                sclkRise;       // synced clock rising edge
   logic                frameOn;        // chip select active
   logic [7:0]          inByte;         // byte completing now
   logic                byteDone;       // last bit of a byte
   logic                readStrobe;     // read access taken
   logic                writeStrobe;    // write access taken
   logic [7:0]          rdData;         // read mux
   logic                softReset;      // soft reset write
   logic                clrStat;        // status register read
   logic                clrData;        // data port read with clear
   logic [SLOT_W-1:0]   slotSrc [4];    // slot sources
   logic [3:0]          slotIsLed;      // slot drives an LED
   logic                ledMode;        // any LED slot in use
   logic [LEVEL_W:0]    afullThr;       // occupancy that trips almost-full
   logic [COUNT_W-1:0]  proxLimit;      // threshold times 2048
   logic                proxBelow;      // count below proximity limit
   logic                proxExit;       // leaving proximity mode
   logic                setAfull;       // almost-full event
   logic                setRdy;         // sample-ready event
   logic                setAlc;         // ambient overflow event
   logic                setProx;        // proximity event
   logic                setComp;        // compliance event
   logic                setPwr;         // power event

   // two-flop sync of the serial pins
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         syncA_r    <= '{sclk: 1'b0, csb: 1'b1, sdi: 1'b0};
         syncB_r    <= '{sclk: 1'b0, csb: 1'b1, sdi: 1'b0};
         sclkPrev_r <= 1'b0;
      end else if (clkEn) begin
         syncA_r    <= spiPins;
         syncB_r    <= syncA_r;
         sclkPrev_r <= syncB_r.sclk;
      end
   end

   // frame decode from the synced pins
   always_comb begin
      sclkRise    = syncB_r.sclk & ~sclkPrev_r;
      frameOn     = ~syncB_r.csb;
      inByte      = {shiftIn_r, syncB_r.sdi};
      byteDone    = frameOn & sclkRise & (bitCnt_r[2:0] == BIT_ADDR[2:0]);
      readStrobe  = byteDone & (bitCnt_r == BIT_CMD) & (inByte == CMD_READ);
      writeStrobe = byteDone & (bitCnt_r == BIT_DATA) & isWrite_r;
   end

   // bit counter, address and command capture
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         bitCnt_r  <= 5'h00;
         shiftIn_r <= 7'h00;
         addr_r    <= REG_RST;
         isWrite_r <= 1'b0;
      end else if (clkEn) begin
         if (!frameOn) begin
            // idle: restart at next frame
            bitCnt_r  <= 5'h00;
            isWrite_r <= 1'b0;
         end else if (sclkRise) begin
            shiftIn_r <= inByte[6:0];
            if (bitCnt_r != BIT_CNT_MAX) begin
               bitCnt_r <= bitCnt_r + 5'h01;
            end
            if (byteDone && bitCnt_r == BIT_ADDR) begin
               addr_r <= inByte;
            end
            if (byteDone && bitCnt_r == BIT_CMD) begin
               isWrite_r <= (inByte == CMD_WRITE);
            end
         end
      end
   end

   // read data shifter, changes just after each sampling edge of the data byte
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         shiftOut_r <= REG_RST;
         sdoOe_r    <= 1'b0;
      end else if (clkEn) begin
         sdoOe_r <= frameOn;
         if (readStrobe) begin
            shiftOut_r <= rdData;
         end else if (frameOn && sclkRise && bitCnt_r > BIT_CMD) begin
            shiftOut_r <= {shiftOut_r[6:0], 1'b0};
         end
      end
   end

   // read mux, unmapped addresses read zero
   always_comb begin
      if (inByte == CMD_READ && addr_r == ADDR_INT_STATUS1) begin
         rdData = status_r;
      end else if (addr_r == ADDR_INT_ENABLE1) begin
         rdData = intEn_r;
      end else if (addr_r == ADDR_FIFO_DATA) begin
         rdData = fifoData;
      end else if (addr_r == ADDR_FIFO_CFG) begin
         rdData = fifoCfg_r;
      end else if (addr_r == ADDR_SLOT_A) begin
         rdData = slotA_r;
      end else if (addr_r == ADDR_SLOT_B) begin
         rdData = slotB_r;
      end else if (addr_r == ADDR_SYS_CTRL) begin
         rdData = sysCtl_r;
      end else if (addr_r == ADDR_SAMP_CFG1) begin
         rdData = cfg1_r;
      end else if (addr_r == ADDR_SAMP_CFG2) begin
         rdData = cfg2_r;
      end else if (addr_r == ADDR_PROX_THR) begin
         rdData = proxThr_r;
      end else if (addr_r == ADDR_LED1_AMP) begin
         rdData = led1_r;
      end else if (addr_r == ADDR_LED2_AMP) begin
         rdData = led2_r;
      end else if (addr_r == ADDR_LED_CURRENT_RANGE) begin
         rdData = range_r;
      end else if (addr_r == ADDR_PILOT_AMP) begin
         rdData = pilot_r;
      end else if (addr_r == ADDR_PART_IDENTITY_FIELD) begin
         rdData = PART_IDENTITY_FIELD_VALUE;
      end else begin
         rdData = REG_RST;
      end
   end

   // read and write side effects
   always_comb begin
      softReset = writeStrobe & (addr_r == ADDR_SYS_CTRL) & inByte[BIT_SOFT_RESET];
      clrStat   = readStrobe & (addr_r == ADDR_INT_STATUS1);
      clrData   = readStrobe & (addr_r == ADDR_FIFO_DATA) & fifoCfg_r[BIT_CLR_ON_READ];
      fifoPop   = readStrobe & (addr_r == ADDR_FIFO_DATA);
   end

   // configuration registers, soft reset returns them to defaults
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         {slotA_r, slotB_r, sysCtl_r, cfg1_r, cfg2_r, proxThr_r} <= {6{REG_RST}};
         {led1_r, led2_r, range_r, pilot_r, intEn_r, fifoCfg_r}  <= {6{REG_RST}};
      end else if (clkEn) begin
         if (softReset) begin
            {slotA_r, slotB_r, sysCtl_r, cfg1_r, cfg2_r, proxThr_r} <= {6{REG_RST}};
            {led1_r, led2_r, range_r, pilot_r, intEn_r, fifoCfg_r}  <= {6{REG_RST}};
         end else if (writeStrobe) begin
            if (addr_r == ADDR_SLOT_A) begin
               slotA_r <= inByte;
            end else if (addr_r == ADDR_SLOT_B) begin
               slotB_r <= inByte;
            end else if (addr_r == ADDR_SYS_CTRL) begin
               sysCtl_r <= inByte & SYS_MASK;
            end else if (addr_r == ADDR_SAMP_CFG1) begin
               cfg1_r <= inByte;
            end else if (addr_r == ADDR_SAMP_CFG2) begin
               cfg2_r <= inByte;
            end else if (addr_r == ADDR_PROX_THR) begin
               proxThr_r <= inByte;
            end else if (addr_r == ADDR_LED1_AMP) begin
               led1_r <= inByte;
            end else if (addr_r == ADDR_LED2_AMP) begin
               led2_r <= inByte;
            end else if (addr_r == ADDR_LED_CURRENT_RANGE) begin
               range_r <= inByte;
            end else if (addr_r == ADDR_PILOT_AMP) begin
               pilot_r <= inByte;
            end else if (addr_r == ADDR_INT_ENABLE1) begin
               intEn_r <= inByte & EN_MASK;
            end else if (addr_r == ADDR_FIFO_CFG) begin
               fifoCfg_r <= inByte;
            end
         end
      end
   end

   // per-slot check for an LED source
   assign slotSrc[0] = slotA_r[SLOT_W-1:0];
   assign slotSrc[1] = slotA_r[2*SLOT_W-1:SLOT_W];
   assign slotSrc[2] = slotB_r[SLOT_W-1:0];
   assign slotSrc[3] = slotB_r[2*SLOT_W-1:SLOT_W];
   for (genvar s = 0; s < 4; s++) begin : g_slot
      assign slotIsLed[s] = (slotSrc[s] == SLOT_LED1) | (slotSrc[s] == SLOT_LED2);
   end
   assign ledMode = |slotIsLed;

   // event qualification
   always_comb begin
      afullThr  = LEVEL_W'(DEPTH) - {3'b000, fifoCfg_r[AFULL_LVL_W-1:0]};
      proxLimit = {proxThr_r, {THRESH_SHIFT{1'b0}}};
      proxBelow = firstLedCount < proxLimit;
      setAfull  = evtIn.sampleWritten & intEn_r[BIT_AFULL]
                & (({1'b0, fifoLevel} + 7'h01) >= afullThr);
      setRdy    = evtIn.sampleWritten & ledMode & intEn_r[BIT_RDY];
      setAlc    = evtIn.ambientOverflow & intEn_r[BIT_ALC];
      setProx   = proxExit & intEn_r[BIT_PROX];
      setComp   = evtIn.sampleEnd & evtIn.ledNotCompliant & intEn_r[BIT_COMP];
      setPwr    = evtIn.uvloEvent | softReset;
   end

   // proximity mode next state
   always_comb begin
      proxState_nxt = proxState_r;
      proxExit      = 1'b0;
      case (proxState_r)
         PROX_NORMAL: begin
            // drop to proximity when count low
            if (intEn_r[BIT_PROX] && evtIn.sampleEnd && proxBelow) begin
               proxState_nxt = PROX_ACTIVE;
            end
         end
         PROX_ACTIVE: begin
            if (!intEn_r[BIT_PROX]) begin
               proxState_nxt = PROX_NORMAL;
            end else if (evtIn.sampleEnd && !proxBelow) begin
               proxState_nxt = PROX_NORMAL;
               proxExit      = 1'b1;
            end
         end
         default: begin
            proxState_nxt = PROX_NORMAL;
         end
      endcase
   end

   // proximity state and first LED current selection
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         proxState_r <= PROX_NORMAL;
         ledDrive_r  <= REG_RST;
      end else if (clkEn) begin
         proxState_r <= proxState_nxt;
         ledDrive_r  <= (proxState_nxt == PROX_ACTIVE) ? pilot_r : led1_r;
      end
   end

   // sticky status flags, a set in the clearing cycle wins
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         status_r <= REG_RST;
      end else if (clkEn) begin
         if (setAfull) begin
            status_r[BIT_AFULL] <= 1'b1;
         end else if (clrStat || clrData) begin
            status_r[BIT_AFULL] <= 1'b0;
         end
         // sample-ready cleared by status read, by data read with the clear option
         if (setRdy) begin
            status_r[BIT_RDY] <= 1'b1;
         end else if (clrStat || clrData) begin
            status_r[BIT_RDY] <= 1'b0;
         end
         // ambient overflow cleared on status read
         if (setAlc) begin
            status_r[BIT_ALC] <= 1'b1;
         end else if (clrStat) begin
            status_r[BIT_ALC] <= 1'b0;
         end
         if (setProx) begin
            status_r[BIT_PROX] <= 1'b1;
         end else if (clrStat) begin
            status_r[BIT_PROX] <= 1'b0;
         end
         // compliance cleared on read, one means fault
         if (setComp) begin
            status_r[BIT_COMP] <= 1'b1;
         end else if (clrStat) begin
            status_r[BIT_COMP] <= 1'b0;
         end
         if (setPwr) begin
            status_r[BIT_PWR] <= 1'b1;
         end else if (clrStat) begin
            status_r[BIT_PWR] <= 1'b0;
         end
      end
   end

   // interrupt from enabled flags plus the power flag, which has no enable
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         intReq_n_r <= 1'b1;
      end else if (clkEn) begin
         intReq_n_r <= ~(|(status_r & (intEn_r | (8'h01 << BIT_PWR))));
      end
   end

   // outputs
   assign sdoData          = shiftOut_r[7];
   assign sdoOe            = sdoOe_r;
   assign intReq_n         = intReq_n_r;
   assign proxModeActive   = (proxState_r == PROX_ACTIVE);
   assign firstLedDrive    = ledDrive_r;
   assign secondLedCurrent = led2_r;
   assign slotSourceA      = slotA_r;
   assign slotSourceB      = slotB_r;
   assign systemCtrl       = sysCtl_r;
   assign samplingCfg1     = cfg1_r;
   assign samplingCfg2     = cfg2_r;
   assign ledCurrentRange  = range_r;

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   a_afull_set: assert property (clkEn && setAfull |=> status_r[BIT_AFULL])
      else $error("almost-full not set");
   a_data_clear: assert property (clkEn && clrData && !setAfull && !setRdy
      |=> !status_r[BIT_AFULL] && !status_r[BIT_RDY]) else $error("data read clear lost");
   a_rdy_set: assert property (clkEn && evtIn.sampleWritten && ledMode
      && intEn_r[BIT_RDY] |=> status_r[BIT_RDY]) else $error("sample-ready not set");
   a_rdy_no_opt: assert property (clkEn && fifoPop && !clrData && status_r[BIT_RDY]
      |=> status_r[BIT_RDY]) else $error("sample-ready cleared without option");
   a_stat_clear: assert property (clkEn && clrStat && !setAlc && !setProx
      |=> !status_r[BIT_ALC] && !status_r[BIT_PROX]) else $error("status read clear lost");
   a_alc_set: assert property (clkEn && evtIn.ambientOverflow && intEn_r[BIT_ALC]
      |=> status_r[BIT_ALC]) else $error("ambient overflow not set");
   a_prox_flag: assert property (clkEn && proxState_r == PROX_ACTIVE && evtIn.sampleEnd
      && !proxBelow && intEn_r[BIT_PROX] |=> status_r[BIT_PROX]) else $error("prox flag missing");
   a_prox_masked: assert property (clkEn && !intEn_r[BIT_PROX]
      |=> proxState_r == PROX_NORMAL && !proxModeActive) else $error("masked prox mode");
   a_comp_set: assert property (clkEn && evtIn.sampleEnd && evtIn.ledNotCompliant
      && intEn_r[BIT_COMP] |=> status_r[BIT_COMP]) else $error("compliance not set");
   a_comp_clear: assert property (clkEn && clrStat && !setComp
      |=> !status_r[BIT_COMP]) else $error("compliance not cleared");
   a_pwr_set: assert property (clkEn && softReset
      |=> status_r[BIT_PWR] && intEn_r == REG_RST) else $error("soft reset power flag");
   a_prox_stay: assert property (clkEn && proxState_r == PROX_ACTIVE
      && intEn_r[BIT_PROX] && proxBelow |=> proxState_r == PROX_ACTIVE ##1 1'b1)
      else $error("left prox mode early");
   a_gate_off: assert property (clkEn && !intEn_r[BIT_RDY] && !status_r[BIT_RDY]
      |=> !status_r[BIT_RDY]) else $error("disabled flag set");
   a_irq_drive: assert property (clkEn && |(status_r & intEn_r)
      |=> !intReq_n) else $error("interrupt not raised");

   c_afull: cover property (setAfull ##[1:100] clrStat);
   c_prox_exit: cover property (proxExit);
   c_soft_reset: cover property (softReset);
   c_data_read: cover property (clrData);

endmodule

/* File: rtl/oafe_pkg.sv */
package oafe_pkg;

   // register offsets on the serial port
   localparam logic [7:0] ADDR_INT_STATUS1 = 8'h00;
   localparam logic [7:0] ADDR_INT_ENABLE1 = 8'h02;
   localparam logic [7:0] ADDR_FIFO_DATA   = 8'h07;
   localparam logic [7:0] ADDR_FIFO_CFG    = 8'h08;
   localparam logic [7:0] ADDR_SLOT_A      = 8'h09;
   localparam logic [7:0] ADDR_SLOT_B      = 8'h0A;
   localparam logic [7:0] ADDR_SYS_CTRL    = 8'h0D;
   localparam logic [7:0] ADDR_SAMP_CFG1   = 8'h0E;
   localparam logic [7:0] ADDR_SAMP_CFG2   = 8'h0F;
   localparam logic [7:0] ADDR_PROX_THR    = 8'h10;
   localparam logic [7:0] ADDR_LED1_AMP    = 8'h11;
   localparam logic [7:0] ADDR_LED2_AMP    = 8'h12;
   localparam logic [7:0] ADDR_LED_CURRENT_RANGE   = 8'h14;
   localparam logic [7:0] ADDR_PILOT_AMP   = 8'h15;
   localparam logic [7:0] ADDR_PART_IDENTITY_FIELD     = 8'hFF;

   // serial frame: address byte, command byte, data byte
   localparam logic [7:0] CMD_WRITE   = 8'h00;
   localparam logic [7:0] CMD_READ    = 8'hFF;
   localparam logic [4:0] BIT_ADDR    = 5'h07;
   localparam logic [4:0] BIT_CMD     = 5'h0F;
   localparam logic [4:0] BIT_DATA    = 5'h17;
   localparam logic [4:0] BIT_CNT_MAX = 5'h1F;

   // status and enable bit positions (shared layout)
   localparam int BIT_AFULL = 7;
   localparam int BIT_RDY   = 6;
   localparam int BIT_ALC   = 5;
   localparam int BIT_PROX  = 4;
   localparam int BIT_COMP  = 3;
   localparam int BIT_PWR   = 0;
   localparam logic [7:0] STAT_MASK = 8'hF9;
   localparam logic [7:0] EN_MASK   = 8'hF8;

   // other fields
   localparam int BIT_SOFT_RESET = 0;
   localparam logic [7:0] SYS_MASK = 8'h1E;
   localparam int BIT_CLR_ON_READ = 6;
   localparam int AFULL_LVL_W     = 4;
   localparam int SLOT_W          = 4;
   localparam logic [3:0] SLOT_LED1 = 4'h1;
   localparam logic [3:0] SLOT_LED2 = 4'h2;
   localparam int THRESH_SHIFT    = 11;
   localparam int COUNT_W         = 19;
   localparam int FIFO_DEPTH      = 32;
   localparam int LEVEL_W         = 6;
   localparam logic [7:0] REG_RST = 8'h00;

   // serial pins as sampled from outside
   typedef struct packed {
      logic sclk;
      logic csb;
      logic sdi;
   } oafe_spi_t;

   // events from the measurement chain and sample buffer
   typedef struct packed {
      logic sampleWritten;    // one-cycle: sample pushed into buffer
      logic sampleEnd;        // one-cycle: sample period closed
      logic ambientOverflow;  // level: ambient cancel out of range
      logic ledNotCompliant;  // level: first LED driver below headroom
      logic uvloEvent;        // one-cycle: supply undervoltage seen
   } oafe_evt_t;

   // proximity operating mode
   typedef enum logic {
      PROX_NORMAL = 1'b0,
      PROX_ACTIVE = 1'b1
   } oafe_prox_t;

endpackage

/* File: verification/oafe_host_model.sv */
`timescale 1ns/1ps
// host side of the serial register port, mode 0, msb first
module oafe_host_model
   import oafe_pkg::*;
(
   input  logic      clk_sys, // system clock
   output oafe_spi_t spiPins, // pins toward device
   input  logic      sdoData, // data from device
   input  logic      sdoOe    // device drives sdo
);
   // idle: clock low, deselected
   initial spiPins = 3'b010;
   // one frame: address, command, data; 4 clk per sclk phase
   task automatic xfer(input logic [23:0] f, output logic [7:0] q);
      @(negedge clk_sys) spiPins.csb = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         spiPins.sdi = f[i];
         repeat (4) @(negedge clk_sys);
         // read bits are taken just before their rising edge
         if (i < 8) q[i] = sdoOe ? sdoData : 1'bx;
         spiPins.sclk = 1'b1;
         repeat (4) @(negedge clk_sys);
         spiPins.sclk = 1'b0;
      end
      repeat (4) @(negedge clk_sys);
      spiPins.csb = 1'b1;
      // released line must not keep its last level
      spiPins.sdi = ~spiPins.sdi;
      repeat (4) @(negedge clk_sys);
   endtask
endmodule

/* File: verification/oafe_irq_regs_tb.sv */
`timescale 1ns/1ps
module oafe_irq_regs_tb
   import oafe_pkg::*;
;
   logic             clk_sys, reset_n, sdoData, sdoOe, intReq_n, prox;
   oafe_spi_t        spiPins;  // serial pins
   oafe_evt_t        evtIn;    // chain events
   logic [5:0]       fifoLevel;
   logic [7:0]       fifoData, drive, q;
   logic [18:0]      cnt;      // first LED count
   int               nFail, checked;
   logic             pop;      // data port read pulse
   logic [7:0]       pops;     // data port reads seen
   oafe_host_model host (.clk_sys(clk_sys), .spiPins(spiPins), .sdoData(sdoData),
      .sdoOe(sdoOe));
   oafe_irq_regs DUT (.clk_sys(clk_sys), .reset_n(reset_n), .clkEn(1'b1),
      .spiPins(spiPins), .sdoData(sdoData), .sdoOe(sdoOe), .evtIn(evtIn),
      .fifoLevel(fifoLevel), .fifoData(fifoData), .fifoPop(pop), .firstLedCount(cnt),
      .intReq_n(intReq_n), .proxModeActive(prox), .firstLedDrive(drive),
      .secondLedCurrent(), .slotSourceA(), .slotSourceB(), .systemCtrl(),
      .samplingCfg1(), .samplingCfg2(), .ledCurrentRange());
   // free running clock
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   // count data port pops away from the launching edge
   initial pops = 8'h00;
   always @(negedge clk_sys) begin
      if (pop === 1'b1) pops <= pops + 8'h01;
   end
   task chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         nFail++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      host.xfer({a, CMD_WRITE, d}, q);
   endtask
   task rdc(input logic [7:0] a, input logic [7:0] e);
      host.xfer({a, CMD_READ, 8'h00}, q);
      chk(q, e);
   endtask
   // one-cycle event pattern, then let flags and interrupt settle
   task ev(input oafe_evt_t e);
      @(negedge clk_sys) evtIn = e;
      @(negedge clk_sys) evtIn = '0;
      repeat (3) @(negedge clk_sys);
   endtask
   task summarize;
      if (nFail == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // watchdog against a hung port
   initial begin
      #200000 nFail++;
      summarize;
   end
   initial begin
      {reset_n, evtIn, fifoLevel, cnt} = '0;
      fifoData = 8'hA5;
      repeat (12) @(negedge clk_sys);
      reset_n = 1'b1;
      repeat (2) @(negedge clk_sys);
      rdc(ADDR_INT_STATUS1, 8'h00);
      rdc(ADDR_PART_IDENTITY_FIELD, 8'h5A);
      rdc(8'h03, 8'h00);
      wr(ADDR_SYS_CTRL, 8'h01);
      chk({7'h0, intReq_n}, 8'h00);
      rdc(ADDR_INT_STATUS1, 8'h01);
      chk({7'h0, intReq_n}, 8'h01);
      ev(5'h01);
      rdc(ADDR_INT_STATUS1, 8'h01);
      wr(ADDR_SLOT_A, 8'h21);
      fifoLevel = 6'd27;
      ev(5'h10);
      rdc(ADDR_INT_STATUS1, 8'h00);
      wr(ADDR_FIFO_CFG, 8'h44);
      wr(ADDR_INT_ENABLE1, EN_MASK);
      fifoLevel = 6'd26;
      ev(5'h10);
      rdc(ADDR_INT_STATUS1, 8'h40);
      fifoLevel = 6'd27;
      ev(5'h10);
      chk({7'h0, intReq_n}, 8'h00);
      rdc(ADDR_INT_STATUS1, 8'hC0);
      ev(5'h10);
      rdc(ADDR_FIFO_DATA, 8'hA5);
      chk(pops, 8'h01);
      rdc(ADDR_INT_STATUS1, 8'h00);
      ev(5'h0E);
      rdc(ADDR_INT_STATUS1, 8'h28);
      rdc(ADDR_INT_STATUS1, 8'h00);
      wr(ADDR_LED1_AMP, 8'h3C);
      wr(ADDR_PILOT_AMP, 8'h05);
      wr(ADDR_PROX_THR, 8'h01);
      rdc(ADDR_PILOT_AMP, 8'h05);
      chk(drive, 8'h3C);
      // just below one threshold step enters proximity
      cnt = 19'd2047;
      ev(5'h08);
      chk({7'h0, prox}, 8'h01);
      chk(drive, 8'h05);
      cnt = 19'd2048;
      ev(5'h08);
      chk({7'h0, prox}, 8'h00);
      rdc(ADDR_INT_STATUS1, 8'h10);
      wr(ADDR_INT_ENABLE1, 8'hE8);
      cnt = 19'd0;
      ev(5'h08);
      chk({7'h0, prox}, 8'h00);
      chk(drive, 8'h3C);
      summarize;
   end
endmodule
